// ==== design/port_power_ctrl.sv ====
// port power control and over-current detection for the downstream ports
// Operation
// [RL1] each port uses one pin for power command and over-current sense
// [RL2] power is commanded by hub logic or by the embedded processor
// [RL3] ganged mode: one shared pin powers and senses all ports
// [RL4] ganged mode comes only from serial-slave or one-time memory configuration
// [RL5] ganged over-current flags every port at once
// [RL6] individual mode out of reset, one pin per port
// [RL7] power off: drive pin low, pull-up disabled
// [RL8] power on: release driver, enable pull-up, open-drain
// [RL9] external switch pulls pin low; low read as over-current
// [RL10] filter out transient lows such as power ramp
// [RL11] sample pin every tick while port powered
// [RL12] consecutive lows for the minimum width flag over-current
// [RL13] two low groups within the rolling window flag over-current
// [RL14] per-port pin signalling of battery-charging supply presence; individual mode only, ganged mode drives every port pin low
// [RL15] single width 4-bit, 1 ms steps, 0 to 5, default 5
// [RL16] double window 8-bit, 1 ms steps, default 20, never zero
// [RL17] lockout after power on, 8-bit ms, default 10, never zero
// [RL18] millisecond tick from core clock shared by all timers
`timescale 1ns/1ps
module port_power_ctrl
  import port_power_pkg::*;
#(
  // core clock cycles per millisecond tick
  parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire logic                 cfg_load,
  input  wire logic                 cfg_gang_mode,
  input  wire logic [3:0]           cfg_min_width,
  input  wire logic [7:0]           cfg_dbl_window,
  input  wire logic [7:0]           cfg_lockout,
  input  wire logic                 proc_ctrl_sel,
  input  wire logic [NUM_PORTS-1:0] hub_pwr_req,
  input  wire logic [NUM_PORTS-1:0] proc_pwr_req,
  input  wire logic [NUM_PORTS-1:0] bc_supply_en,
  input  wire logic [NUM_PORTS-1:0] oc_clear,
  input  wire logic [NUM_PORTS-1:0] port_power_sense_pins_in,
  output logic      [NUM_PORTS-1:0] port_power_sense_pins_out,
  output logic      [NUM_PORTS-1:0] port_power_sense_pins_oe_b,
  output logic      [NUM_PORTS-1:0] port_power_sense_pins_pu_en,
  input  wire logic                 shared_power_sense_pin_in,
  output logic                      shared_power_sense_pin_out,
  output logic                      shared_power_sense_pin_oe_b,
  output logic                      shared_power_sense_pin_pu_en,
  output logic      [NUM_PORTS-1:0] oc_flag,
  output logic      [NUM_PORTS-1:0] port_pwr_on,
  output logic                      gang_mode
);

  logic [TICK_CNT_W-1:0] tick_cnt_ff;
  logic                  tick_ff;
  logic                  gang_ff;
  logic [3:0]            min_width_ff;
  logic [7:0]            dbl_window_ff;
  logic [7:0]            lockout_ff;
  logic [NUM_PORTS-1:0]  oc_flag_ff;
  logic [NUM_PORTS-1:0]  pwr_on_ff;
  logic [NUM_PORTS-1:0]  chan_event;
  logic                  gang_event;

  // -------------------------------------------------------------
  // millisecond timebase
  // -------------------------------------------------------------
  // one-cycle tick every millisecond of core clock
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end
    else if (tick_cnt_ff == TICK_CNT_W'(TICK_DIV - 1))
    begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b1;                              // [RL18]
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      tick_ff     <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // configuration
  // -------------------------------------------------------------
  // mode and timings change only on a configuration load strobe;
  // zero window or lockout values are kept out by forcing one
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gang_ff       <= 1'b0;                            // [RL6]
      min_width_ff  <= MIN_WIDTH_RST;                   // [RL15]
      dbl_window_ff <= DBL_WIN_RST;                     // [RL16]
      lockout_ff    <= LOCKOUT_RST;                     // [RL17]
    end
    else if (cfg_load)
    begin
      gang_ff       <= cfg_gang_mode;                   // [RL4]
      min_width_ff  <= cfg_min_width;
      dbl_window_ff <= (cfg_dbl_window == 8'h0) ? 8'h1 : cfg_dbl_window;  // [RL16]
      lockout_ff    <= (cfg_lockout == 8'h0) ? 8'h1 : cfg_lockout;        // [RL17]
    end
  end

  assign gang_mode = gang_ff;

  // -------------------------------------------------------------
  // power requests
  // -------------------------------------------------------------
  // hub logic or processor owns the power commands
  wire [NUM_PORTS-1:0] pwr_req = proc_ctrl_sel ? proc_pwr_req : hub_pwr_req;  // [RL2]
  // in ganged mode any request powers all ports together
  wire [NUM_PORTS-1:0] pwr_sel = gang_ff ? {NUM_PORTS{|pwr_req}} : pwr_req;    // [RL3]

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      pwr_on_ff <= '0;
    else
      pwr_on_ff <= pwr_sel;
  end

  assign port_pwr_on = pwr_on_ff;

  // -------------------------------------------------------------
  // per-port channels
  // -------------------------------------------------------------
  // in individual mode a battery-charging port holds its pin released with pull-up
  // so the external supply sees the charger indication
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++)
    begin : g_port
      wire chan_pwr = !gang_ff && (pwr_on_ff[gi] || bc_supply_en[gi]);  // [RL6] [RL14]
      oc_sense_chan u_chan (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .ms_tick    (tick_ff),
        .pwr_on     (chan_pwr),
        .min_width  (min_width_ff),
        .dbl_window (dbl_window_ff),
        .lockout    (lockout_ff),
        .pin_in     (port_power_sense_pins_in[gi]),
        .pin_out    (port_power_sense_pins_out[gi]),
        .pin_oe_b   (port_power_sense_pins_oe_b[gi]),
        .pullup_en  (port_power_sense_pins_pu_en[gi]),
        .oc_event   (chan_event[gi])
      );
    end
  endgenerate

  // shared ganged channel
  wire shared_power_sense_pin = gang_ff && (|pwr_on_ff);              // [RL3]
  oc_sense_chan u_gang (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .ms_tick    (tick_ff),
    .pwr_on     (shared_power_sense_pin),
    .min_width  (min_width_ff),
    .dbl_window (dbl_window_ff),
    .lockout    (lockout_ff),
    .pin_in     (shared_power_sense_pin_in),
    .pin_out    (shared_power_sense_pin_out),
    .pin_oe_b   (shared_power_sense_pin_oe_b),
    .pullup_en  (shared_power_sense_pin_pu_en),
    .oc_event   (gang_event)
  );

  // -------------------------------------------------------------
  // over-current flags
  // -------------------------------------------------------------
  // shared event sets every port flag at once
  wire [NUM_PORTS-1:0] oc_set = chan_event | {NUM_PORTS{gang_event}};  // [RL5]

  // sticky flags, a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      oc_flag_ff <= '0;
    else
      oc_flag_ff <= oc_set | (oc_flag_ff & ~oc_clear);
  end

  assign oc_flag = oc_flag_ff;

endmodule // port_power_ctrl

// ==== design/port_power_pkg.sv ====
// constants and types shared by the port power and over-current logic
package port_power_pkg;

  // number of downstream ports
  localparam int unsigned NUM_PORTS = 6;

  // core clock and millisecond timebase
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned TICK_TIME_NS  = 1000000;
  localparam int unsigned TICK_CYCLES   = (TICK_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned TICK_CNT_W    = 18;

  // reset values of the timing settings
  localparam logic [3:0] MIN_WIDTH_RST = 4'h5;
  localparam logic [7:0] DBL_WIN_RST   = 8'h14;
  localparam logic [7:0] LOCKOUT_RST   = 8'h0a;

  // largest legal single-pulse code
  localparam logic [3:0] MIN_WIDTH_MAX = 4'h5;

  // state of one port sensing channel
  typedef enum logic [1:0] {
    CH_OFF,
    CH_LOCKOUT,
    CH_SENSE
  } chan_state_t;

endpackage

// ==== design/oc_sense_chan.sv ====
// one channel: drives the shared power/sense pin and filters its level
`timescale 1ns/1ps
module oc_sense_chan
  import port_power_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       ms_tick,
  input  wire logic       pwr_on,
  input  wire logic [3:0] min_width,
  input  wire logic [7:0] dbl_window,
  input  wire logic [7:0] lockout,
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe_b,
  output logic            pullup_en,
  output logic            oc_event
);

  chan_state_t state_ff;
  chan_state_t nxt_state;
  logic [7:0]  lock_cnt_ff;
  logic [3:0]  low_cnt_ff;
  logic [7:0]  win_cnt_ff;
  logic        win_open_ff;
  logic        prev_low_ff;
  logic        oc_ff;

  // -------------------------------------------------------------
  // pin drive
  // -------------------------------------------------------------
  // off: drive 0 with pull-up off; on: release, pull-up on
  assign pin_out   = 1'b0;                     // [RL1] [RL7]
  assign pin_oe_b  = pwr_on;                   // [RL7] [RL8]
  assign pullup_en = pwr_on;                   // [RL8]
  assign oc_event  = oc_ff;

  // -------------------------------------------------------------
  // filter decode
  // -------------------------------------------------------------
  // low level read from the switch is an over-current request
  // gated by pwr_on so the pin's own low drive just after power-off is never sampled
  wire sample    = (state_ff == CH_SENSE) && pwr_on && ms_tick;  // [RL11] [RL18]
  wire is_low    = ~pin_in;                             // [RL9]
  wire new_group = sample && is_low && !prev_low_ff;
  wire [3:0] clamp_width = (min_width > MIN_WIDTH_MAX) ? MIN_WIDTH_MAX : min_width;
  // single pulse: consecutive low samples reach the minimum width
  // one bit wider so a saturated run count does not wrap to zero
  wire single_hit = sample && is_low && (({1'b0, low_cnt_ff} + 5'h01) >= {1'b0, clamp_width});  // [RL12] [RL15]
  // double pulse: second low group while the window is open
  wire double_hit = new_group && win_open_ff;           // [RL13] [RL16]
  wire lock_done  = ms_tick && (lock_cnt_ff <= 8'h1);   // [RL17]

  // state selection
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      CH_OFF:     if (pwr_on) nxt_state = CH_LOCKOUT;
      CH_LOCKOUT: if (!pwr_on) nxt_state = CH_OFF;
                  else if (lock_done) nxt_state = CH_SENSE;
      CH_SENSE:   if (!pwr_on) nxt_state = CH_OFF;
      default:    nxt_state = CH_OFF;
    endcase
  end

  // state register and lockout counter, pin ignored while locked out
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff    <= CH_OFF;
      lock_cnt_ff <= 8'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff != CH_LOCKOUT)
        lock_cnt_ff <= lockout;                         // [RL17]
      else if (ms_tick)
        lock_cnt_ff <= lock_cnt_ff - 8'h1;
    end
  end

  // low run length and previous sample for group edges
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_cnt_ff  <= 4'h0;
      prev_low_ff <= 1'b0;
    end
    else if (state_ff != CH_SENSE)
    begin
      low_cnt_ff  <= 4'h0;
      prev_low_ff <= 1'b0;
    end
    else if (sample)
    begin
      prev_low_ff <= is_low;
      if (!is_low)
        low_cnt_ff <= 4'h0;
      else if (low_cnt_ff != 4'hf)
        low_cnt_ff <= low_cnt_ff + 4'h1;
    end
  end

  // rolling window opened by the first low group
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      win_open_ff <= 1'b0;
      win_cnt_ff  <= 8'h0;
    end
    else if (state_ff != CH_SENSE)
      win_open_ff <= 1'b0;
    else if (new_group && !win_open_ff)
    begin
      win_open_ff <= 1'b1;                              // [RL13]
      win_cnt_ff  <= dbl_window;
    end
    else if (sample && win_open_ff)
    begin
      if (win_cnt_ff <= 8'h1)
        win_open_ff <= 1'b0;
      win_cnt_ff <= win_cnt_ff - 8'h1;
    end
  end

  // one-cycle over-current event, transients filtered away
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      oc_ff <= 1'b0;
    else
      oc_ff <= single_hit || double_hit;                // [RL10]
  end

endmodule // oc_sense_chan

// ==== testbench/power_switch_model.sv ====
// behavioural external power switch driving the sense level of each pin
`timescale 1ns/1ps
module power_switch_model
  import port_power_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic [NUM_PORTS-1:0] drv_oe_b,
  input  wire logic [NUM_PORTS-1:0] drv_pu_en,
  input  wire logic                 shr_oe_b,
  input  wire logic                 shr_pu_en,
  input  wire logic [NUM_PORTS-1:0] fault,
  input  wire logic                 shr_fault,
  output logic      [NUM_PORTS-1:0] pins_lvl,
  output logic                      shr_lvl
);
  logic float_ff = 1'b0;

  // an undriven line without pull-up shows a changing level
  always_ff @(posedge ref_clk) float_ff <= ~float_ff;

  // driven low, pulled low by the switch on a fault, pulled up, or floating
  always_comb
  begin
    for (int i = 0; i < NUM_PORTS; i++)
      pins_lvl[i] = !drv_oe_b[i] ? 1'b0 : fault[i] ? 1'b0 : drv_pu_en[i] ? 1'b1 : float_ff;
    shr_lvl = !shr_oe_b ? 1'b0 : shr_fault ? 1'b0 : shr_pu_en ? 1'b1 : float_ff;
  end
endmodule // power_switch_model

// ==== testbench/port_power_ctrl_chk.sv ====
// assertions on the pin, power and flag outputs of the port power block
`timescale 1ns/1ps
module port_power_ctrl_chk
  import port_power_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 rst_b,
  input wire logic                 cfg_load,
  input wire logic                 proc_ctrl_sel,
  input wire logic [NUM_PORTS-1:0] hub_pwr_req,
  input wire logic [NUM_PORTS-1:0] proc_pwr_req,
  input wire logic [NUM_PORTS-1:0] bc_supply_en,
  input wire logic [NUM_PORTS-1:0] port_power_sense_pins_out,
  input wire logic [NUM_PORTS-1:0] port_power_sense_pins_oe_b,
  input wire logic [NUM_PORTS-1:0] port_power_sense_pins_pu_en,
  input wire logic                 shared_power_sense_pin_oe_b,
  input wire logic [NUM_PORTS-1:0] oc_flag,
  input wire logic [NUM_PORTS-1:0] port_pwr_on,
  input wire logic                 gang_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // request of the selected control source
  wire [NUM_PORTS-1:0] sel_req = proc_ctrl_sel ? proc_pwr_req : hub_pwr_req;

  property p_out_low; port_power_sense_pins_out == '0 && port_power_sense_pins_pu_en == port_power_sense_pins_oe_b;
  endproperty
  a_out_low: assert property (p_out_low) else $error("pin drive or pull-up wrong");
  property p_indiv_pwr; $past(rst_b) && !gang_mode && $past(!gang_mode) |-> port_pwr_on == $past(sel_req); endproperty
  a_indiv_pwr: assert property (p_indiv_pwr) else $error("power does not follow request");
  property p_indiv_pin;
    $past(rst_b) && !gang_mode && $stable(bc_supply_en) |-> port_power_sense_pins_oe_b == (port_pwr_on | bc_supply_en);
  endproperty
  a_indiv_pin: assert property (p_indiv_pin) else $error("pin release wrong");
  property p_shared_power_sense_pin; $past(rst_b) && gang_mode && $past(gang_mode) |-> port_pwr_on == {NUM_PORTS{|$past(sel_req)}};
  endproperty
  a_shared_power_sense_pin: assert property (p_shared_power_sense_pin) else $error("ganged power not shared");
  property p_gang_pins;
    gang_mode && $past(gang_mode) |-> port_power_sense_pins_oe_b == '0 && shared_power_sense_pin_oe_b == |port_pwr_on;
  endproperty
  a_gang_pins: assert property (p_gang_pins) else $error("ganged pins wrong");
  property p_gang_load; gang_mode != $past(gang_mode) |-> $past(cfg_load); endproperty
  a_gang_load: assert property (p_gang_load) else $error("mode changed without load");
  property p_gang_flags; gang_mode && $past(gang_mode) && (oc_flag & ~$past(oc_flag)) != '0 |-> &oc_flag; endproperty
  a_gang_flags: assert property (p_gang_flags) else $error("ganged flag not on all ports");
  property p_flag_power; (oc_flag & ~$past(oc_flag)) != '0 |-> (oc_flag & ~$past(oc_flag) & ~$past(port_pwr_on, 2)) == '0;
  endproperty
  a_flag_power: assert property (p_flag_power) else $error("flag on unpowered port");

  c_gang: cover property ($rose(gang_mode));
  c_all_on: cover property (gang_mode && &port_pwr_on);
  c_bc: cover property (!gang_mode && bc_supply_en != '0 && port_pwr_on == '0);
endmodule // port_power_ctrl_chk

bind port_power_ctrl port_power_ctrl_chk u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .cfg_load(cfg_load), .proc_ctrl_sel(proc_ctrl_sel),
  .hub_pwr_req(hub_pwr_req), .proc_pwr_req(proc_pwr_req), .bc_supply_en(bc_supply_en),
  .port_power_sense_pins_out(port_power_sense_pins_out), .port_power_sense_pins_oe_b(port_power_sense_pins_oe_b),
  .port_power_sense_pins_pu_en(port_power_sense_pins_pu_en),
  .shared_power_sense_pin_oe_b(shared_power_sense_pin_oe_b), .oc_flag(oc_flag),
  .port_pwr_on(port_pwr_on), .gang_mode(gang_mode));

// ==== testbench/tb_port_power_ctrl.sv ====
// self-checking bench for port power control and pin handling
`timescale 1ns/1ps
module tb_port_power_ctrl;
  import port_power_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, cfg_load = 1'b0, cfg_gang_mode = 1'b0, proc_ctrl_sel = 1'b0;
  logic [3:0] cfg_min_width = MIN_WIDTH_RST;
  logic [7:0] cfg_dbl_window = DBL_WIN_RST, cfg_lockout = LOCKOUT_RST;
  logic [NUM_PORTS-1:0] hub_pwr_req = '0, proc_pwr_req = '0, bc_supply_en = '0, oc_clear = '0, fault = '0;
  logic [NUM_PORTS-1:0] pins_in, oe_b, pu_en, oc_flag, port_pwr_on;
  logic shr_in, shr_oe_b, shr_pu_en, gang_mode;
  logic shr_fault = 1'b0;
  // short millisecond tick so the filter and lockout timers fit the run
  localparam int unsigned TB_TICK = 20;
  int error_cnt = 0, num_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  port_power_ctrl #(.TICK_DIV(TB_TICK)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .cfg_load(cfg_load),
    .cfg_gang_mode(cfg_gang_mode),
    .cfg_min_width(cfg_min_width), .cfg_dbl_window(cfg_dbl_window), .cfg_lockout(cfg_lockout),
    .proc_ctrl_sel(proc_ctrl_sel), .hub_pwr_req(hub_pwr_req), .proc_pwr_req(proc_pwr_req),
    .bc_supply_en(bc_supply_en), .oc_clear(oc_clear), .port_power_sense_pins_in(pins_in),
    .port_power_sense_pins_out(), .port_power_sense_pins_oe_b(oe_b), .port_power_sense_pins_pu_en(pu_en),
    .shared_power_sense_pin_in(shr_in), .shared_power_sense_pin_out(), .shared_power_sense_pin_oe_b(shr_oe_b),
    .shared_power_sense_pin_pu_en(shr_pu_en), .oc_flag(oc_flag), .port_pwr_on(port_pwr_on), .gang_mode(gang_mode));

  power_switch_model u_sw (.ref_clk(ref_clk), .drv_oe_b(oe_b), .drv_pu_en(pu_en), .shr_oe_b(shr_oe_b),
    .shr_pu_en(shr_pu_en), .fault(fault), .shr_fault(shr_fault), .pins_lvl(pins_in), .shr_lvl(shr_in));

  // wait edges, then move off the sampling edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // reset holds pins low and selects individual mode
  task automatic t_reset;
    step(10);
    chk(oe_b, 8'h00);
    chk(pu_en, 8'h00);
    rst_b = 1'b1;
    step(1);
    chk(gang_mode, 8'h00);
    chk(oc_flag, 8'h00);
  endtask

  // each port on its own, then the processor source, then a fault in lockout
  task automatic t_indiv;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      hub_pwr_req = NUM_PORTS'(1 << i);
      step(1);
      chk(port_pwr_on, 8'(1 << i));
      chk(oe_b, 8'(1 << i));
      chk(pu_en, 8'(1 << i));
      chk(pins_in, 8'(1 << i));
    end
    proc_ctrl_sel = 1'b1;
    proc_pwr_req = 6'h2a;
    step(1);
    chk(port_pwr_on, 8'h2a);
    fault = 6'h0a;
    step(100);
    chk(oc_flag, 8'h00);
    step(220);
    chk(oc_flag, 8'h0a);
    fault = '0;
    proc_pwr_req = '0;
    step(1);
    chk(oe_b, 8'h00);
    oc_clear = '1;
    step(1);
    oc_clear = '0;
    step(2 * TB_TICK);
    chk(oc_flag, 8'h00);
  endtask

  // one short low group filtered, a second group in the window and a long low both flag
  task automatic t_filter;
    cfg_min_width = 4'h3;
    cfg_lockout = 8'h02;
    cfg_load = 1'b1;
    step(1);
    cfg_load = 1'b0;
    proc_pwr_req = 6'h03;
    step(3 * TB_TICK);
    fault = 6'h01;
    step(30);
    fault = '0;
    step(2 * TB_TICK);
    chk(oc_flag, 8'h00);
    fault = 6'h01;
    step(30);
    fault = '0;
    step(5);
    chk(oc_flag, 8'h01);
    fault = 6'h02;
    step(70);
    fault = '0;
    step(5);
    chk(oc_flag, 8'h03);
    proc_pwr_req = '0;
    oc_clear = '1;
    step(1);
    oc_clear = '0;
    chk(oc_flag, 8'h00);
  endtask

  // charger indication releases the pin of an unpowered port
  task automatic t_bc;
    bc_supply_en = 6'h05;
    step(2);
    chk(oe_b, 8'h05);
    chk(port_pwr_on, 8'h00);
    bc_supply_en = '0;
  endtask

  // mode taken only at load; ganged power and shared pin
  task automatic t_gang;
    cfg_gang_mode = 1'b1;
    step(2);
    chk(gang_mode, 8'h00);
    cfg_load = 1'b1;
    step(1);
    cfg_load = 1'b0;
    proc_pwr_req = 6'h04;
    step(2);
    chk(gang_mode, 8'h01);
    chk(port_pwr_on, 8'h3f);
    chk(oe_b, 8'h00);
    chk(shr_oe_b, 8'h01);
    chk(shr_in, 8'h01);
    step(3 * TB_TICK);
    shr_fault = 1'b1;
    step(2);
    chk(shr_in, 8'h00);
    step(70);
    shr_fault = 1'b0;
    step(5);
    chk(oc_flag, 8'h3f);
  endtask

  initial
  begin
    t_reset();
    t_indiv();
    t_bc();
    t_filter();
    t_gang();
    close_out();
  end
endmodule // tb_port_power_ctrl
